// ===== hw/pei_cfg.svh
// register map, field positions, reset values and thresholds for the phy event interrupt block
`ifndef PEI_CFG_SVH
`define PEI_CFG_SVH
`define PEI_IDX_CTRL 5'h11
`define PEI_IDX_ISR 5'h12
`define PEI_IDX_FCC 5'h14
`define PEI_IDX_REC 5'h15
`define PEI_IDX_LINK 5'h16
`define PEI_CTRL_FDCOL 4
`define PEI_CTRL_POL 3
`define PEI_CTRL_TINT 2
`define PEI_CTRL_GEN 1
`define PEI_CTRL_OE 0
`define PEI_CTRL_RST 16'h0008
`define PEI_CTRL_WMASK 16'h001f
`define PEI_ISR_FLAG_LSB 8
`define PEI_ISR_EN_MASK 6'h3f
`define PEI_FLAG_LINK 5
`define PEI_FLAG_SPEED 4
`define PEI_FLAG_DUPLEX 3
`define PEI_FLAG_AN 2
`define PEI_FLAG_FC 1
`define PEI_FLAG_RE 0
`define PEI_PIN_RST 1'b1
`define PEI_FCC_HALF 8'h7f
`define PEI_FCC_MAX 8'hff
`define PEI_REC_HALF 16'h7fff
`define PEI_REC_MAX 16'hffff
`define PEI_LINK_LINK 0
`define PEI_LINK_SPEED 1
`define PEI_LINK_DUPLEX 2
`define PEI_LINK_ANDONE 3
`define PEI_RDATA_BAD 32'h0000_0000
`endif

// ===== hw/pei_pkg.sv
// types shared by the phy event interrupt block
package pei_pkg;
   typedef struct packed {
      logic link_up;
      logic speed_100;
      logic full_duplex;
      logic an_complete;
      logic false_carrier;
      logic rx_error;
      logic collision_raw;
   } pei_phy_status_t;
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } pei_bus_req_t;
   typedef enum logic [1:0] {
      PEI_IDLE = 2'b00,
      PEI_ACT = 2'b01,
      PEI_DONE = 2'b11
   } pei_bus_state_t;
endpackage

// ===== hw/pei_sat_counter.sv
// saturating event counter with clear-on-read and half-full crossing pulse
`timescale 1ns/1ps
`default_nettype none
module pei_sat_counter #(
   parameter int W = 8,
   parameter logic [W-1:0] HALF = '0,
   parameter logic [W-1:0] MAX = '1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // event and control
   input wire logic inc,
   input wire logic clr,
   // state
   output logic [W-1:0] count,
   output logic half_pulse
);
   logic [W-1:0] count_next;
   wire do_inc = inc && (count != MAX);
   assign count_next = clr ? '0 : (do_inc ? count + 1'b1 : count);
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         count <= '0;
         half_pulse <= 1'b0;
      end else begin
         count <= count_next;
         half_pulse <= !clr && do_inc && (count == HALF);
      end
   end
endmodule
`default_nettype wire

// ===== hw/pei_top.sv
// phy event interrupt logic: control register, latched event status, counters, interrupt pin
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "pei_cfg.svh"

module pei_top
   import pei_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // avalon-mm slave, word address
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // phy status from the core
   input wire pei_phy_status_t phy_status,
   // collision indication to the mac
   output logic col_out,
   // shared interrupt / power-down pin
   input wire logic irq_or_powerdown_pin_in,
   output logic irq_or_powerdown_pin_out,
   output logic irq_or_powerdown_pin_oe,
   output logic powerdown_req
);
   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: two wait cycles, answer in the third
   pei_bus_state_t bus_state_reg;
   pei_bus_state_t bus_state_next;
   pei_bus_req_t req;
   assign req = '{read: avs_read, write: avs_write, address: avs_address, writedata: avs_writedata};
   wire bus_req = req.read || req.write;
   always_comb begin
      case (bus_state_reg)
         PEI_IDLE: bus_state_next = bus_req ? PEI_ACT : PEI_IDLE;
         PEI_ACT: bus_state_next = PEI_DONE;
         PEI_DONE: bus_state_next = PEI_IDLE;
         default: bus_state_next = PEI_IDLE;
      endcase
   end
   wire bus_fire = (bus_state_reg == PEI_ACT);
   wire rd_fire = bus_fire && req.read;
   wire wr_fire = bus_fire && req.write;
   wire sel_ctrl = (req.address == {3'h0, `PEI_IDX_CTRL});
   wire sel_isr = (req.address == {3'h0, `PEI_IDX_ISR});
   wire sel_fcc = (req.address == {3'h0, `PEI_IDX_FCC});
   wire sel_rec = (req.address == {3'h0, `PEI_IDX_REC});
   wire sel_link = (req.address == {3'h0, `PEI_IDX_LINK});

   // clear-on-read strobes for the counters
   wire fcc_clr = rd_fire && sel_fcc;
   wire rec_clr = rd_fire && sel_rec;

   ////////////////////////////////////////////////////////////////////////////
   // control register
   wire ctrl_wr = wr_fire && sel_ctrl;
   wire [15:0] ctrl_wdata = req.writedata[15:0] & `PEI_CTRL_WMASK;
   wire [15:0] ctrl_rst = `PEI_CTRL_RST;
   logic fdcol_reg;
   logic pol_reg;
   logic tint_reg;
   logic gen_reg;
   logic oe_reg;
   wire fdcol_next = ctrl_wr ? ctrl_wdata[`PEI_CTRL_FDCOL] : fdcol_reg;
   wire pol_next = ctrl_wr ? ctrl_wdata[`PEI_CTRL_POL] : pol_reg;
   wire tint_next = ctrl_wr ? ctrl_wdata[`PEI_CTRL_TINT] : tint_reg;
   wire gen_next = ctrl_wr ? ctrl_wdata[`PEI_CTRL_GEN] : gen_reg;
   wire oe_field_next = ctrl_wr ? ctrl_wdata[`PEI_CTRL_OE] : oe_reg;
   wire fdcol_en = fdcol_reg;
   wire pol_bit = pol_reg;
   wire tint_bit = tint_reg;
   wire gen_bit = gen_reg;
   wire oe_bit = oe_reg;
   wire [15:0] ctrl_view = {11'h000, fdcol_reg, pol_reg, tint_reg, gen_reg, oe_reg};

   ////////////////////////////////////////////////////////////////////////////
   // event detection
   logic [3:0] prev_reg;
   logic [3:0] cur_lvl;
   assign cur_lvl = {phy_status.an_complete, phy_status.full_duplex, phy_status.speed_100, phy_status.link_up};
   wire link_now = cur_lvl[`PEI_LINK_LINK];
   wire link_was = prev_reg[`PEI_LINK_LINK];
   wire speed_now = cur_lvl[`PEI_LINK_SPEED];
   wire speed_was = prev_reg[`PEI_LINK_SPEED];
   wire duplex_now = cur_lvl[`PEI_LINK_DUPLEX];
   wire duplex_was = prev_reg[`PEI_LINK_DUPLEX];
   wire an_now = cur_lvl[`PEI_LINK_ANDONE];
   wire an_was = prev_reg[`PEI_LINK_ANDONE];

   // link, speed and duplex fire on any change, auto-negotiation on completion only
   wire ev_link = link_now != link_was;
   wire ev_speed = speed_now != speed_was;
   wire ev_duplex = duplex_now != duplex_was;
   wire ev_an = an_now && !an_was;

   ////////////////////////////////////////////////////////////////////////////
   // counters
   logic [7:0] fcc_count;
   logic [15:0] rec_count;
   logic fcc_half;
   logic rec_half;
   // false-carrier counter
   pei_sat_counter #(.W(8), .HALF(`PEI_FCC_HALF), .MAX(`PEI_FCC_MAX)) u_fcc (
      .mclk(mclk),
      .rst_b(rst_b),
      .inc(phy_status.false_carrier),
      .clr(fcc_clr),
      .count(fcc_count),
      .half_pulse(fcc_half)
   );

   // receive-error counter
   pei_sat_counter #(.W(16), .HALF(`PEI_REC_HALF), .MAX(`PEI_REC_MAX)) u_rec (
      .mclk(mclk),
      .rst_b(rst_b),
      .inc(phy_status.rx_error),
      .clr(rec_clr),
      .count(rec_count),
      .half_pulse(rec_half)
   );
   ////////////////////////////////////////////////////////////////////////////
   // status flags and enables
   logic [5:0] flag_reg;
   logic [5:0] flag_next;
   logic [5:0] en_reg;
   logic [5:0] en_next;
   logic [5:0] ev_vec;
   assign ev_vec = {ev_link, ev_speed, ev_duplex, ev_an, fcc_half, rec_half};

   // a status read clears the flags, but an event in the same cycle still sets its flag
   wire flag_clr = rd_fire && sel_isr;
   wire [5:0] flag_keep = flag_clr ? 6'h00 : flag_reg;
   wire link_flag_next = flag_keep[`PEI_FLAG_LINK] || ev_vec[`PEI_FLAG_LINK];
   wire speed_flag_next = flag_keep[`PEI_FLAG_SPEED] || ev_vec[`PEI_FLAG_SPEED];
   wire duplex_flag_next = flag_keep[`PEI_FLAG_DUPLEX] || ev_vec[`PEI_FLAG_DUPLEX];
   wire an_flag_next = flag_keep[`PEI_FLAG_AN] || ev_vec[`PEI_FLAG_AN];
   wire fc_flag_next = flag_keep[`PEI_FLAG_FC] || ev_vec[`PEI_FLAG_FC];
   wire re_flag_next = flag_keep[`PEI_FLAG_RE] || ev_vec[`PEI_FLAG_RE];
   // enables never gate the flags
   assign flag_next = {link_flag_next, speed_flag_next, duplex_flag_next,
                       an_flag_next, fc_flag_next, re_flag_next};

   // per-event enables
   wire en_wr = wr_fire && sel_isr;
   wire [5:0] en_wdata = req.writedata[5:0] & `PEI_ISR_EN_MASK;
   wire link_en_next = en_wr ? en_wdata[`PEI_FLAG_LINK] : en_reg[`PEI_FLAG_LINK];
   wire speed_en_next = en_wr ? en_wdata[`PEI_FLAG_SPEED] : en_reg[`PEI_FLAG_SPEED];
   wire duplex_en_next = en_wr ? en_wdata[`PEI_FLAG_DUPLEX] : en_reg[`PEI_FLAG_DUPLEX];
   wire an_en_next = en_wr ? en_wdata[`PEI_FLAG_AN] : en_reg[`PEI_FLAG_AN];
   wire fc_en_next = en_wr ? en_wdata[`PEI_FLAG_FC] : en_reg[`PEI_FLAG_FC];
   wire re_en_next = en_wr ? en_wdata[`PEI_FLAG_RE] : en_reg[`PEI_FLAG_RE];
   assign en_next = {link_en_next, speed_en_next, duplex_en_next,
                     an_en_next, fc_en_next, re_en_next};

   wire [15:0] isr_view = {2'b00, flag_reg, 2'b00, en_reg};

   ////////////////////////////////////////////////////////////////////////////
   // interrupt request and pin
   // per-event requests
   wire irq_link = flag_reg[`PEI_FLAG_LINK] && en_reg[`PEI_FLAG_LINK];
   wire irq_speed = flag_reg[`PEI_FLAG_SPEED] && en_reg[`PEI_FLAG_SPEED];
   wire irq_duplex = flag_reg[`PEI_FLAG_DUPLEX] && en_reg[`PEI_FLAG_DUPLEX];
   wire irq_an = flag_reg[`PEI_FLAG_AN] && en_reg[`PEI_FLAG_AN];
   wire irq_fc = flag_reg[`PEI_FLAG_FC] && en_reg[`PEI_FLAG_FC];
   wire irq_re = flag_reg[`PEI_FLAG_RE] && en_reg[`PEI_FLAG_RE];
   wire any_irq = irq_link || irq_speed || irq_duplex || irq_an || irq_fc || irq_re;
   wire ev_gate = gen_bit && oe_bit;
   wire ev_irq = ev_gate && any_irq;
   wire irq_req = tint_bit || ev_irq;
   wire pin_level = pol_bit ? !irq_req : irq_req;

   // pin enable and power-down input
   wire oe_next = oe_bit;
   wire pd_next = !oe_bit && !irq_or_powerdown_pin_in;

   // collision to the mac
   wire col_half = phy_status.collision_raw && !phy_status.full_duplex;
   wire col_full = phy_status.collision_raw && phy_status.full_duplex && fdcol_en;
   wire col_next = col_half || col_full;

   // bus answer
   wire wait_next = !bus_fire;

   ////////////////////////////////////////////////////////////////////////////
   // read data
   wire [31:0] ctrl_rd = {16'h0000, ctrl_view};
   wire [31:0] isr_rd = {16'h0000, isr_view};
   wire [31:0] fcc_rd = {24'h000000, fcc_count};
   wire [31:0] rec_rd = {16'h0000, rec_count};
   wire [31:0] link_rd = {28'h0000000, cur_lvl};

   logic [31:0] rdata_next;
   assign rdata_next = !rd_fire ? 32'h0000_0000 :
                       sel_ctrl ? ctrl_rd :
                       sel_isr ? isr_rd :
                       sel_fcc ? fcc_rd :
                       sel_rec ? rec_rd :
                       sel_link ? link_rd : `PEI_RDATA_BAD;

   ////////////////////////////////////////////////////////////////////////////
   // registers

   // bus sequencer
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         bus_state_reg <= PEI_IDLE;
      end else begin
         bus_state_reg <= bus_state_next;
      end
   end

   // full-duplex collision enable
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         fdcol_reg <= ctrl_rst[`PEI_CTRL_FDCOL];
      end else begin
         fdcol_reg <= fdcol_next;
      end
   end

   // pin polarity
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pol_reg <= ctrl_rst[`PEI_CTRL_POL];
      end else begin
         pol_reg <= pol_next;
      end
   end

   // test interrupt
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         tint_reg <= ctrl_rst[`PEI_CTRL_TINT];
      end else begin
         tint_reg <= tint_next;
      end
   end

   // global event enable
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         gen_reg <= ctrl_rst[`PEI_CTRL_GEN];
      end else begin
         gen_reg <= gen_next;
      end
   end

   // pin output enable
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         oe_reg <= ctrl_rst[`PEI_CTRL_OE];
      end else begin
         oe_reg <= oe_field_next;
      end
   end

   // previous live levels, loaded with the present levels in reset so no false change follows
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         prev_reg <= cur_lvl;
      end else begin
         prev_reg <= cur_lvl;
      end
   end

   // event flags
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         flag_reg <= 6'h00;
      end else begin
         flag_reg <= flag_next;
      end
   end

   // event enables
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         en_reg <= 6'h00;
      end else begin
         en_reg <= en_next;
      end
   end

   // read data
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_readdata <= rdata_next;
      end
   end

   // waitrequest
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= wait_next;
      end
   end

   // collision
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         col_out <= 1'b0;
      end else begin
         col_out <= col_next;
      end
   end

   // pin drive level
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         irq_or_powerdown_pin_out <= `PEI_PIN_RST;
      end else begin
         irq_or_powerdown_pin_out <= pin_level;
      end
   end

   // pin enable
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         irq_or_powerdown_pin_oe <= 1'b0;
      end else begin
         irq_or_powerdown_pin_oe <= oe_next;
      end
   end

   // power-down request
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         powerdown_req <= 1'b0;
      end else begin
         powerdown_req <= pd_next;
      end
   end
endmodule
`default_nettype wire

// ===== test/pei_host_pin.sv
// host side of the shared interrupt / power-down pin
`timescale 1ns/1ps
`default_nettype none
module pei_host_pin (
   // pin drive from the block
   input wire logic pin_out,
   input wire logic pin_oe,
   // host power-down request, active low
   input wire logic pd_b,
   // resolved pin level
   output logic pin
);
   // host drives the pin only while the block does not
   assign pin = pin_oe ? pin_out : pd_b;
endmodule
`default_nettype wire

// ===== test/pei_top_checker.sv
// assertions on the ports of the phy event interrupt block
`timescale 1ns/1ps
`default_nettype none
module pei_top_checker
   import pei_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // register bus
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // phy side and pin
   input wire pei_phy_status_t phy_status,
   input wire logic col_out,
   input wire logic irq_or_powerdown_pin_out,
   input wire logic irq_or_powerdown_pin_oe
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   a_rst_pin: assert property (disable iff (1'b0) !rst_b |=>
      irq_or_powerdown_pin_out && !irq_or_powerdown_pin_oe) else $error("pin not idle after reset");
   a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
   a_wait_bound: assert property ($rose(avs_read) |-> ##[1:3] !avs_waitrequest) else $error("read not answered");
   a_idle_zero: assert property (avs_waitrequest |-> avs_readdata == 32'h0) else $error("readdata not zero");
   a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0) else $error("upper bits set");
   a_isr_resv: assert property (!avs_waitrequest && avs_address == 8'h12 |->
      avs_readdata[15:14] == 2'h0 && avs_readdata[7:6] == 2'h0) else $error("status reserved bits set");
   a_ctrl_resv: assert property (!avs_waitrequest && avs_address == 8'h11 |->
      avs_readdata[15:5] == 11'h0) else $error("control upper bits set");
   a_col_half: assert property (phy_status.collision_raw && !phy_status.full_duplex |=> col_out)
      else $error("half duplex collision lost");
   a_col_cause: assert property (col_out |-> $past(phy_status.collision_raw)) else $error("collision without cause");
endmodule
bind pei_top pei_top_checker pei_top_checker_i (.mclk, .rst_b, .avs_address, .avs_read, .avs_readdata,
   .avs_waitrequest, .phy_status, .col_out, .irq_or_powerdown_pin_out, .irq_or_powerdown_pin_oe);
`default_nettype wire

// ===== test/tb_pei_top.sv
// testbench for the phy event interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_pei_top;
   import pei_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic pd_b = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata, got;
   logic wt, col, p_out, p_oe, pd_req, pin;
   pei_phy_status_t st = '0;
   int n_errors = 0;
   int checks = 0;
   pei_top pei_top_i (.mclk, .rst_b, .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_readdata(rdata), .avs_waitrequest(wt), .phy_status(st), .col_out(col), .irq_or_powerdown_pin_in(pin),
      .irq_or_powerdown_pin_out(p_out), .irq_or_powerdown_pin_oe(p_oe), .powerdown_req(pd_req));
   pei_host_pin pei_host_pin_i (.pin_out(p_out), .pin_oe(p_oe), .pd_b, .pin);
   initial forever #2 mclk = ~mclk;
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      wr <= w;
      rd <= !w;
      adr <= a;
      wd <= d;
      do @(posedge mclk); while (wt !== 1'b0);
      got = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rdc(logic [7:0] a, logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, got);
   endtask
   task automatic pw(int n, logic e);
      repeat (n) @(posedge mclk);
      chk("pin", {31'h0, e}, {31'h0, p_out});
   endtask
   task automatic t_reset;
      rdc(8'h11, 32'h8);
      rdc(8'h12, 32'h0);
      pw(1, 1'b1);
      chk("oe", 32'h0, {31'h0, p_oe});
      pd_b <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("powerdown", 32'h1, {31'h0, pd_req});
      pd_b <= 1'b1;
      $display("reset test done");
   endtask
   task automatic t_events;
      st <= 7'b1111110;
      repeat (32768) @(posedge mclk);
      st.false_carrier <= 1'b0;
      st.rx_error <= 1'b0;
      repeat (2) @(posedge mclk);
      rdc(8'h14, 32'hff);
      rdc(8'h15, 32'h8000);
      rdc(8'h12, 32'h3f00);
      rdc(8'h12, 32'h0);
      rdc(8'h14, 32'h0);
      $display("event test done");
   endtask
   task automatic t_irq;
      bus(1'b1, 8'h12, 32'hffff);
      rdc(8'h12, 32'h3f);
      bus(1'b1, 8'h20, 32'hffff);
      rdc(8'h20, 32'h0);
      bus(1'b1, 8'h11, 32'hb);
      chk("oe", 32'h1, {31'h0, p_oe});
      st.link_up <= 1'b0;
      pw(4, 1'b0);
      bus(1'b1, 8'h11, 32'h9);
      pw(3, 1'b1);
      bus(1'b1, 8'h11, 32'hb);
      pw(3, 1'b0);
      rdc(8'h12, 32'h203f);
      pw(3, 1'b1);
      bus(1'b1, 8'h11, 32'hd);
      pw(3, 1'b0);
      bus(1'b1, 8'h11, 32'h5);
      pw(3, 1'b1);
      bus(1'b1, 8'h11, 32'h1);
      pw(3, 1'b0);
      $display("interrupt test done");
   endtask
   task automatic t_col;
      st.collision_raw <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("col", 32'h0, {31'h0, col});
      bus(1'b1, 8'h11, 32'h10);
      repeat (2) @(posedge mclk);
      chk("col", 32'h1, {31'h0, col});
      bus(1'b1, 8'h11, 32'h0);
      st.full_duplex <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("col half", 32'h1, {31'h0, col});
      st.collision_raw <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("col idle", 32'h0, {31'h0, col});
      $display("collision test done");
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #(4 * 40000);
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_events();
      t_irq();
      t_col();
      finish_test();
   end
endmodule
`default_nettype wire
